// >>> core/pcc_core.sv
// Register file, double buffering, temperature ADC control and VCO calibration sequencer.
`timescale 1ns/10ps
module pcc_core #(
    parameter logic [11:0] CORE_SPLIT = 12'h0C8,
    parameter logic [8:0] TEMP_OFFSET = 9'h040
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [pcc_pkg::IDX_W-1:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    input wire logic pfd_tick_i,
    input wire logic vco_fast_i,
    input wire logic lock_det_i,
    input wire logic [7:0] adc_sample_i,
    output logic [11:0] nint_o,
    output logic [5:0] rdiv_o,
    output logic doubler_o,
    output logic [3:0] pump_current_o,
    output logic [2:0] output_divider_o,
    output logic [1:0] cal_clock_divider_o,
    output logic cal_clock_halving_o,
    output logic output_inversion_o,
    output logic bleed_direction_o,
    output logic [2:0] lock_window_select_o,
    output logic integer_mode_o,
    output logic large_bleed_o,
    output logic debug_node_selector_o,
    output logic four_wire_select_o,
    output logic tuning_voltage_precharge_o,
    output logic vco_core_o,
    output logic [8:0] vco_band_o,
    output logic [3:0] vco_bias_o
);
    import pcc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Avalon slave: one wait state on every access, all indices mapped.
    logic ack_q;
    logic [7:0] regs_q [0:255];
    logic [7:0] sptr_q;
    logic [31:0] rd_q;
    logic load_q;
    wire req = read_i | write_i;
    wire is_stream = address_i == IDX_STR_DATA;
    wire [7:0] acc_idx = is_stream ? sptr_q : address_i;
    wire wr_go = write_i & ack_q & byteenable_i[0];
    wire [7:0] wd = writedata_i[7:0];
    wire wr_nint_lo = wr_go & (acc_idx == IDX_NINT_LO);
    wire wr_sptr = wr_go & (address_i == IDX_STR_ADDR);

    assign waitrequest_o = req & ~ack_q;
    assign readdata_o = rd_q;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < 256; i++) begin
                regs_q[i] <= REG_RESET;
            end
        end else if (wr_go) begin
            regs_q[acc_idx] <= wd;
        end
    end

    // A stream starts at the pointer written once, then walks upward.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sptr_q <= REG_RESET;
        end else if (wr_sptr) begin
            sptr_q <= wd;
        end else if (wr_go & is_stream) begin
            sptr_q <= sptr_q + 8'h01;
        end
    end

    // The copy waits one cycle so the new low byte is already in the array.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            load_q <= 1'b0;
        end else begin
            load_q <= wr_nint_lo;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main copies and buffer enables.
    wire [7:0] ctrl = regs_q[IDX_ADC_CTRL];
    wire [7:0] dbuf = regs_q[IDX_DBUF];
    wire [11:0] nint_m = {regs_q[IDX_NINT_HI][3:0], regs_q[IDX_NINT_LO]};
    wire inv_m = regs_q[IDX_NINT_HI][4];
    wire [5:0] rdiv_m = regs_q[IDX_RDIV][5:0];
    wire dbl_m = regs_q[IDX_CP_DBL][0];
    wire [3:0] cp_m = regs_q[IDX_CP_DBL][7:4];
    wire [2:0] odiv_m = regs_q[IDX_DIVS][2:0];
    wire [1:0] cdiv_m = regs_q[IDX_DIVS][4:3];
    wire chalf_m = regs_q[IDX_DIVS][5];
    wire bpol_m = dbuf[4];
    wire db_odiv = dbuf[0];
    wire db_cdiv = dbuf[1];
    wire db_dly = dbuf[2];
    wire manual = regs_q[IDX_MANUAL][0];
    wire [15:0] pre_to = {regs_q[IDX_PRE_HI], regs_q[IDX_PRE_LO]};
    wire [15:0] dec_to = {regs_q[IDX_DEC_HI], regs_q[IDX_DEC_LO]};
    wire [7:0] set_to = regs_q[IDX_SETTLE];
    wire [3:0] mux_sel = regs_q[IDX_MUX][7:4];
    wire [2:0] lwin = regs_q[IDX_LOCKWIN][7:5];

    ////////////////////////////////////////////////////////////////////////////
    // Subordinate copies drive the device; lock window, mode flags and four-wire select come straight from the main copies.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            nint_o <= 12'h000;
            rdiv_o <= 6'h00;
            doubler_o <= 1'b0;
            pump_current_o <= 4'h0;
        end else if (load_q) begin
            nint_o <= nint_m;
            rdiv_o <= rdiv_m;
            doubler_o <= dbl_m;
            pump_current_o <= cp_m;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            output_divider_o <= 3'h0;
            cal_clock_divider_o <= 2'h0;
            cal_clock_halving_o <= 1'b0;
            output_inversion_o <= 1'b0;
            bleed_direction_o <= 1'b0;
        end else begin
            if (load_q | ~db_odiv) output_divider_o <= odiv_m;
            if (load_q | ~db_cdiv) cal_clock_divider_o <= cdiv_m;
            cal_clock_halving_o <= chalf_m;
            if (load_q | ~db_dly) begin
                output_inversion_o <= inv_m;
                bleed_direction_o <= bpol_m;
            end
        end
    end

    assign lock_window_select_o = lwin;
    assign integer_mode_o = lwin[2:1] == 2'h0;
    assign large_bleed_o = lwin == 3'h1;
    assign four_wire_select_o = regs_q[IDX_SERIAL][FOUR_WIRE_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Calibration and ADC clocks, one-cycle enables from the PFD rate.
    logic [3:0] pcnt_q;
    wire clk_on = ctrl[REF_CLK_EN_BIT] & ctrl[FB_CLK_EN_BIT];
    wire [2:0] rsh = {1'b0, cal_clock_divider_o} + {2'b00, cal_clock_halving_o};
    wire [3:0] cmask = 4'((5'h01 << cal_clock_divider_o) - 5'h01);
    wire [3:0] rmask = 4'((5'h01 << rsh) - 5'h01);
    wire cal_tick = pfd_tick_i & clk_on & ((pcnt_q & cmask) == cmask);
    wire rclk_tick = pfd_tick_i & clk_on & ((pcnt_q & rmask) == rmask);

    always_ff @(posedge clk_i) begin
        if (reset_i | ~clk_on) begin
            pcnt_q <= 4'h0;
        end else if (pfd_tick_i) begin
            pcnt_q <= pcnt_q + 4'h1;
        end
    end

    // The ADC clock follows the divided reference but is rate limited so
    // that a fast PFD can never push it past its maximum.
    logic [5:0] gap_q;
    wire adc_run = ctrl[ADC_CONV_EN_BIT] & ctrl[ADC_EN_BIT] & ctrl[ADC_CLK_EN_BIT]
        & ~ctrl[ADC_PD_BIT];
    wire adc_tick = rclk_tick & adc_run & (gap_q == ADC_GAP_MAX);

    always_ff @(posedge clk_i) begin
        if (reset_i | adc_tick) begin
            gap_q <= 6'h00;
        end else if (gap_q != ADC_GAP_MAX) begin
            gap_q <= gap_q + 6'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Temperature conversion.
    logic conv_busy_q;
    logic [4:0] ccnt_q;
    logic [8:0] temp_q;
    wire conv_start = wr_go & (acc_idx == IDX_ADC_CTRL) & wd[ADC_START_BIT];
    wire conv_done = conv_busy_q & adc_tick & (ccnt_q == ADC_LAST_TICK);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            conv_busy_q <= 1'b0;
        end else if (conv_start) begin
            conv_busy_q <= 1'b1;
        end else if (conv_done) begin
            conv_busy_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i | conv_start) begin
            ccnt_q <= 5'h00;
        end else if (conv_busy_q & adc_tick) begin
            ccnt_q <= ccnt_q + 5'h01;
        end
    end

    // Offset binary to signed Celsius; bit 8 set means below zero.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            temp_q <= 9'h000;
        end else if (conv_done) begin
            temp_q <= {1'b0, adc_sample_i} - TEMP_OFFSET;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // VCO calibration sequencer.
    pcc_cal_e state_q, state_d;
    logic [19:0] cnt_q;
    logic [3:0] bit_q;
    wire cal_go = load_q & ~manual;
    wire in_vcal = state_q == CAL_VCAL;
    wire step = in_vcal ? rclk_tick : cal_tick;
    wire [19:0] tgt = (state_q == CAL_PRE) ? {4'h0, pre_to} :
        (state_q == CAL_DECIDE) ? {dec_to, 4'h0} :
        (state_q == CAL_SETTLE) ? {12'h000, set_to} : VCAL_TICKS;
    wire phase_end = step & (({1'b0, cnt_q} + 21'h000001) >= {1'b0, tgt});
    wire last_bit = bit_q == 4'h0;
    wire [8:0] bm = 9'h001 << bit_q;
    wire [8:0] band_d = (vco_band_o & ~bm) | (vco_fast_i ? 9'h000 : bm)
        | (last_bit ? 9'h000 : (bm >> 1));

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            CAL_IDLE: state_d = CAL_IDLE;
            CAL_PRE: if (phase_end) state_d = CAL_DECIDE;
            CAL_DECIDE: if (phase_end) state_d = CAL_SETTLE;
            CAL_SETTLE: if (phase_end) state_d = last_bit ? CAL_VCAL : CAL_DECIDE;
            CAL_VCAL: if (phase_end) state_d = CAL_IDLE;
            default: state_d = CAL_IDLE;
        endcase
    end

    // A fresh trigger restarts the sequence from precharge.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_q <= CAL_IDLE;
        end else begin
            state_q <= cal_go ? CAL_PRE : state_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i | cal_go | (state_d != state_q)) begin
            cnt_q <= 20'h00000;
        end else if (step) begin
            cnt_q <= cnt_q + 20'h00001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i | cal_go) begin
            bit_q <= BAND_TOP_BIT;
        end else if ((state_q == CAL_SETTLE) & phase_end & ~last_bit) begin
            bit_q <= bit_q - 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            vco_band_o <= 9'h000;
            vco_core_o <= 1'b0;
            vco_bias_o <= 4'h0;
        end else if (load_q & manual) begin
            vco_band_o <= {regs_q[IDX_CAL_MISC][0], regs_q[IDX_CAL_BAND]};
            vco_core_o <= regs_q[IDX_CAL_MISC][1];
            vco_bias_o <= regs_q[IDX_CAL_MISC][7:4];
        end else if (cal_go) begin
            vco_band_o <= 9'h100;
            vco_core_o <= nint_m >= CORE_SPLIT;
        end else if ((state_q == CAL_DECIDE) & phase_end) begin
            vco_band_o <= band_d;
        end else if (in_vcal & phase_end) begin
            vco_bias_o <= vco_band_o[8:5];
        end
    end

    assign tuning_voltage_precharge_o = state_q == CAL_PRE;

    ////////////////////////////////////////////////////////////////////////////
    // Status, read-back and debug pin.
    wire cal_busy = state_q != CAL_IDLE;
    wire adc_busy = conv_busy_q | (state_q == CAL_PRE);
    wire [7:0] status = {4'h0, cal_busy, adc_busy, 2'b00} | {7'h00, lock_det_i};
    wire [7:0] rd_val = (acc_idx == IDX_STATUS) ? status :
        (acc_idx == IDX_TEMP_LO) ? temp_q[7:0] :
        (acc_idx == IDX_TEMP_HI) ? {7'h00, temp_q[8]} :
        (acc_idx == IDX_CAL_BAND) ? vco_band_o[7:0] :
        (acc_idx == IDX_CAL_MISC) ? {vco_bias_o, 2'b00, vco_core_o, vco_band_o[8]} :
        regs_q[acc_idx];
    wire [15:0] mux_vec = {9'h000, cal_tick, rclk_tick, tuning_voltage_precharge_o,
        cal_busy, adc_busy, lock_det_i, 1'b0};

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rd_q <= 32'h00000000;
            debug_node_selector_o <= 1'b0;
        end else begin
            if (read_i & ~ack_q) rd_q <= {24'h000000, rd_val};
            debug_node_selector_o <= mux_vec[mux_sel];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    logic [4:0] tk_q;
    logic [3:0] dec_q;
    always_ff @(posedge clk_i) begin
        if (reset_i | conv_start) tk_q <= 5'h00;
        else if (conv_busy_q & adc_tick) tk_q <= tk_q + 5'h01;
        if (reset_i | cal_go) dec_q <= 4'h0;
        else if ((state_q == CAL_DECIDE) & phase_end) dec_q <= dec_q + 4'h1;
    end

    a_adc_busy_rise: assert property (@(posedge clk_i) disable iff (reset_i)
        conv_start |=> conv_busy_q) else $error("adc busy did not rise on start");
    a_conv_tick_count: assert property (@(posedge clk_i) disable iff (reset_i)
        $fell(conv_busy_q) |-> $past(tk_q) == 5'h10 && tk_q == 5'h11)
        else $error("conversion length is not 17 ticks");
    a_adc_rate_limit: assert property (@(posedge clk_i) disable iff (reset_i)
        adc_tick |=> !adc_tick [*8]) else $error("adc clock too fast");
    a_buffer_hold: assert property (@(posedge clk_i) disable iff (reset_i)
        !load_q |=> $stable(nint_o)) else $error("buffered field changed without load");
    a_load_copy: assert property (@(posedge clk_i) disable iff (reset_i)
        wr_nint_lo ##1 load_q |=> nint_o == $past(nint_m))
        else $error("main copy not transferred");
    a_cal_trigger: assert property (@(posedge clk_i) disable iff (reset_i)
        wr_nint_lo && !manual |-> ##2 cal_busy && adc_busy)
        else $error("calibration did not start");
    a_unbuf_track: assert property (@(posedge clk_i) disable iff (reset_i)
        !db_odiv |=> output_divider_o == $past(odiv_m))
        else $error("unbuffered divider not immediate");
    a_nine_decisions: assert property (@(posedge clk_i) disable iff (reset_i)
        $rose(in_vcal) |-> dec_q == 4'h9) else $error("band decision count wrong");
    a_busy_order: assert property (@(posedge clk_i) disable iff (reset_i)
        $fell(cal_busy) && !cal_go |-> !tuning_voltage_precharge_o && $past(in_vcal))
        else $error("sequencer ended outside final step");
    a_mux_select: assert property (@(posedge clk_i) disable iff (reset_i)
        ##1 debug_node_selector_o == $past(mux_vec[mux_sel])) else $error("debug pin wrong node");
endmodule // pcc_core

// >>> core/pcc_pkg.sv
// Constants, register indices and state codes for the PLL configuration and calibration control.
package pcc_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned ADC_MAX_HZ = 400_000;
    localparam int unsigned ADC_MIN_CYC = (CLK_HZ + ADC_MAX_HZ - 1) / ADC_MAX_HZ;
    localparam logic [5:0] ADC_GAP_MAX = 6'(ADC_MIN_CYC - 1);
    localparam logic [4:0] ADC_LAST_TICK = 5'h10;
    localparam logic [3:0] BAND_TOP_BIT = 4'h8;
    localparam logic [19:0] VCAL_TICKS = 20'h00002;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int IDX_W = 8;
    localparam logic [7:0] IDX_SERIAL = 8'h00;
    localparam logic [7:0] IDX_NINT_LO = 8'h10;
    localparam logic [7:0] IDX_NINT_HI = 8'h11;
    localparam logic [7:0] IDX_RDIV = 8'h20;
    localparam logic [7:0] IDX_CP_DBL = 8'h21;
    localparam logic [7:0] IDX_DIVS = 8'h22;
    localparam logic [7:0] IDX_DBUF = 8'h23;
    localparam logic [7:0] IDX_PRE_LO = 8'h24;
    localparam logic [7:0] IDX_PRE_HI = 8'h25;
    localparam logic [7:0] IDX_DEC_LO = 8'h26;
    localparam logic [7:0] IDX_DEC_HI = 8'h27;
    localparam logic [7:0] IDX_SETTLE = 8'h28;
    localparam logic [7:0] IDX_LOCKWIN = 8'h2C;
    localparam logic [7:0] IDX_MUX = 8'h2E;
    localparam logic [7:0] IDX_CAL_BAND = 8'h30;
    localparam logic [7:0] IDX_CAL_MISC = 8'h31;
    localparam logic [7:0] IDX_MANUAL = 8'h32;
    localparam logic [7:0] IDX_STR_ADDR = 8'h3E;
    localparam logic [7:0] IDX_STR_DATA = 8'h3F;
    localparam logic [7:0] IDX_ADC_CTRL = 8'h54;
    localparam logic [7:0] IDX_STATUS = 8'h58;
    localparam logic [7:0] IDX_TEMP_LO = 8'h5B;
    localparam logic [7:0] IDX_TEMP_HI = 8'h5C;
    localparam int FOUR_WIRE_BIT = 3;
    localparam int ADC_START_BIT = 0;
    localparam int ADC_CONV_EN_BIT = 1;
    localparam int REF_CLK_EN_BIT = 2;
    localparam int FB_CLK_EN_BIT = 3;
    localparam int ADC_PD_BIT = 4;
    localparam int ADC_EN_BIT = 5;
    localparam int ADC_CLK_EN_BIT = 6;
    localparam int STAT_ADC_BUSY = 2;
    localparam int STAT_CAL_BUSY = 3;

    typedef enum logic [4:0] {
        CAL_IDLE = 5'b00001,
        CAL_PRE = 5'b00010,
        CAL_DECIDE = 5'b00100,
        CAL_SETTLE = 5'b01000,
        CAL_VCAL = 5'b10000
    } pcc_cal_e;
endpackage

// >>> test/pcc_analog_model.sv
// Behavioural model of the analogue side: PFD tick source, VCO comparator and ADC code.
`timescale 1ns/10ps
module pcc_analog_model #(
    parameter int PFD_DIV = 4,
    parameter logic [7:0] SAMPLE = 8'h30
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic fast_level_i,
    output logic pfd_tick_o,
    output logic vco_fast_o,
    output logic [7:0] adc_sample_o
);
    logic [7:0] div_q;
    logic [7:0] div_d;
    logic wrap;
    assign wrap = (div_q == 8'(PFD_DIV - 1));
    assign div_d = wrap ? 8'h00 : div_q + 8'h01;
    // One-clock pulse, so the PFD rate never exceeds the system clock.
    always_ff @(posedge clk_i) begin
        div_q <= reset_i ? 8'h00 : div_d;
    end
    assign pfd_tick_o = wrap && !reset_i;
    // The comparator level is steered by the bench, so results stay predictable.
    assign vco_fast_o = fast_level_i;
    assign adc_sample_o = SAMPLE;
endmodule // pcc_analog_model

// >>> test/pll_config_cal_control_test.sv
// Self-checking bench for the PLL configuration and calibration control.
`timescale 1ns/10ps
module pll_config_cal_control_test;
    import pcc_pkg::*;
    localparam int PFD_DIV = 4;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] address_i = 8'h00;
    logic read_i = 1'b0;
    logic write_i = 1'b0;
    logic [31:0] writedata_i = 32'h0;
    logic [3:0] byteenable_i = 4'hF;
    logic fast_level = 1'b0;
    logic lock_det_i = 1'b0;
    logic pfd_tick;
    logic vco_fast;
    logic [7:0] adc_sample;
    logic [31:0] readdata_o;
    logic waitrequest_o;
    logic [11:0] nint_o;
    logic [5:0] rdiv_o;
    logic doubler_o;
    logic [3:0] pump_o;
    logic [2:0] odiv_o;
    logic [1:0] cdiv_o;
    logic halv_o;
    logic inv_o;
    logic bleed_o;
    logic [2:0] lws_o;
    logic int_o;
    logic large_o;
    logic mux_o;
    logic four_o;
    logic pre_o;
    logic core_o;
    logic [8:0] band_o;
    logic [3:0] bias_o;
    int miscompares = 0;
    int tests_run = 0;
    int cyc = 0;
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;
    pcc_analog_model #(.PFD_DIV(PFD_DIV)) model (.clk_i(clk_i), .reset_i(reset_i),
        .fast_level_i(fast_level), .pfd_tick_o(pfd_tick), .vco_fast_o(vco_fast),
        .adc_sample_o(adc_sample));
    pcc_core uut (.clk_i(clk_i), .reset_i(reset_i), .address_i(address_i), .read_i(read_i),
        .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
        .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .pfd_tick_i(pfd_tick),
        .vco_fast_i(vco_fast), .lock_det_i(lock_det_i), .adc_sample_i(adc_sample),
        .nint_o(nint_o), .rdiv_o(rdiv_o), .doubler_o(doubler_o), .pump_current_o(pump_o),
        .output_divider_o(odiv_o), .cal_clock_divider_o(cdiv_o), .cal_clock_halving_o(halv_o),
        .output_inversion_o(inv_o), .bleed_direction_o(bleed_o), .lock_window_select_o(lws_o),
        .integer_mode_o(int_o), .large_bleed_o(large_o), .debug_node_selector_o(mux_o),
        .four_wire_select_o(four_o), .tuning_voltage_precharge_o(pre_o), .vco_core_o(core_o),
        .vco_band_o(band_o), .vco_bias_o(bias_o));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            miscompares++;
        end
    endtask
    // The request stands until waitrequest is sampled low at a rising edge; read data is
    // taken at that same edge and only then is the request released.
    task automatic bus(input logic wr_n, input logic [7:0] a, input logic [7:0] d,
        output logic [31:0] q);
        @(posedge clk_i);
        address_i <= a;
        writedata_i <= {24'h0, d};
        write_i <= !wr_n;
        read_i <= wr_n;
        do @(posedge clk_i); while (waitrequest_o !== 1'b0);
        q = readdata_o;
        write_i <= 1'b0;
        read_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b0, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        bus(1'b1, a, 8'h00, q);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_buffer();
        wr(8'h23, 8'h17);
        wr(8'h11, 8'h13);
        wr(8'h20, 8'h05);
        wr(8'h21, 8'h51);
        wr(8'h22, 8'h0B);
        // Give an unbuffered path time to show itself before judging the hold.
        repeat (2) @(posedge clk_i);
        check(32'({nint_o, rdiv_o, doubler_o, pump_o}), 32'h0);
        check(32'({odiv_o, cdiv_o, inv_o, bleed_o}), 32'h0);
        wr(8'h10, 8'h2A);
        repeat (2) @(posedge clk_i);
        check(32'({nint_o, rdiv_o, doubler_o, pump_o}), 32'({12'h32A, 6'h05, 1'b1, 4'h5}));
        check(32'({odiv_o, cdiv_o, inv_o, bleed_o}), 32'h37);
    endtask
    task automatic t_unbuffered();
        wr(8'h23, 8'h00);
        wr(8'h22, 8'h25);
        wr(8'h11, 8'h03);
        repeat (2) @(posedge clk_i);
        check(32'({odiv_o, cdiv_o, halv_o, inv_o}), 32'h52);
        wr(8'h22, 8'h05);
    endtask
    task automatic t_modes();
        for (int c = 0; c < 8; c++) begin
            wr(8'h2C, 8'(c << 5));
            @(posedge clk_i);
            check(32'({lws_o, int_o, large_o}), 32'((c << 2) | ((c < 2) << 1) | (c == 1)));
        end
        wr(IDX_SERIAL, 8'h08);
        @(posedge clk_i);
        check(32'(four_o), 32'h1);
        wr(IDX_SERIAL, 8'h00);
        @(posedge clk_i);
        check(32'(four_o), 32'h0);
        lock_det_i <= 1'b1;
        wr(8'h2E, 8'h10);
        repeat (3) @(posedge clk_i);
        check(32'(mux_o), 32'h1);
        lock_det_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        check(32'(mux_o), 32'h0);
    endtask
    task automatic t_stream();
        logic [31:0] q;
        wr(8'h3E, 8'h24);
        wr(8'h3F, 8'h11);
        wr(8'h3F, 8'h22);
        rd(8'h24, q);
        check(q, 32'h11);
        rd(8'h25, q);
        check(q, 32'h22);
        byteenable_i <= 4'hE;
        wr(8'h24, 8'h77);
        byteenable_i <= 4'hF;
        rd(8'h24, q);
        check(q, 32'h11);
    endtask
    task automatic t_cal(input logic fast, input logic [7:0] lo, input logic [8:0] band,
        input logic core);
        logic [31:0] q;
        logic seen;
        logic adc_fell;
        int t0;
        int n;
        fast_level <= fast;
        wr(8'h24, 8'h08);
        wr(8'h25, 8'h00);
        wr(8'h26, 8'h01);
        wr(8'h27, 8'h00);
        wr(8'h28, 8'h01);
        wr(IDX_ADC_CTRL, 8'h0C);
        wr(8'h10, lo);
        t0 = cyc;
        rd(IDX_STATUS, q);
        check(32'(q[3:2]), 32'h3);
        seen = 1'b0;
        repeat (12) begin
            @(posedge clk_i);
            seen = seen | (pre_o === 1'b1);
        end
        check(32'(seen), 32'h1);
        adc_fell = 1'b0;
        n = 0;
        do begin
            rd(IDX_STATUS, q);
            adc_fell = adc_fell | (q[3] === 1'b1 && q[2] === 1'b0);
            n++;
        end while (q[3] === 1'b1 && n < 400);
        check(32'(adc_fell), 32'h1);
        // Precharge 8, nine decisions of 16 plus one settle, two final ticks.
        check(32'((cyc - t0) >= 163 * PFD_DIV - 8 && (cyc - t0) <= 163 * PFD_DIV + 40), 32'h1);
        check(32'({core_o, band_o, bias_o}), 32'({core, band, band[8:5]}));
        rd(IDX_CAL_BAND, q);
        check(q, 32'(band[7:0]));
        wr(IDX_ADC_CTRL, 8'h00);
    endtask
    task automatic t_manual();
        logic [31:0] q;
        wr(IDX_CAL_BAND, 8'h5A);
        wr(IDX_CAL_MISC, 8'h33);
        wr(IDX_MANUAL, 8'h01);
        wr(8'h10, 8'h2A);
        repeat (2) @(posedge clk_i);
        check(32'({core_o, band_o, bias_o}), 32'({1'b1, 9'h15A, 4'h3}));
        rd(IDX_STATUS, q);
        check(32'(q[3]), 32'h0);
        wr(IDX_MANUAL, 8'h00);
    endtask
    task automatic t_temp();
        logic [31:0] q;
        int t0;
        wr(IDX_ADC_CTRL, 8'h6E);
        wr(IDX_ADC_CTRL, 8'h6F);
        t0 = cyc;
        rd(IDX_STATUS, q);
        check(32'(q[STAT_ADC_BUSY]), 32'h1);
        do rd(IDX_STATUS, q); while (q[STAT_ADC_BUSY] === 1'b1);
        check(32'((cyc - t0) >= 16 * ADC_MIN_CYC), 32'h1);
        check(32'((cyc - t0) <= 18 * (ADC_MIN_CYC + PFD_DIV) + 8), 32'h1);
        rd(IDX_TEMP_LO, q);
        check(q, 32'hF0);
        rd(IDX_TEMP_HI, q);
        check(32'(q[0]), 32'h1);
        wr(IDX_ADC_CTRL, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] q;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        rd(IDX_STATUS, q);
        check(q, 32'h0);
        check(32'({nint_o, mux_o, four_o}), 32'h0);
        t_buffer();
        t_unbuffered();
        t_modes();
        t_stream();
        t_cal(1'b0, 8'h2A, 9'h1FF, 1'b1);
        wr(8'h11, 8'h00);
        t_cal(1'b1, 8'h64, 9'h000, 1'b0);
        t_manual();
        t_temp();
        end_of_test();
    end
    // Whole run is a few thousand cycles; this leaves ample margin.
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        end_of_test();
    end
endmodule // pll_config_cal_control_test
